//--- src/rpmc_map.svh
`ifndef RPMC_MAP_SVH
`define RPMC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RPMC_OFF_SLOT      16'h4018
`define RPMC_OFF_RECCTL    16'h4019
`define RPMC_OFF_ATTEN_L   16'h401A
`define RPMC_OFF_ATTEN_R   16'h401B
`define RPMC_OFF_MIX_L     16'h401C
`define RPMC_OFF_MIX_R     16'h401E

// ----------------------------------------------------------------
// Readable bit masks (reserved bits read zero)
// ----------------------------------------------------------------
`define RPMC_MASK_SLOT     8'h03
`define RPMC_MASK_RECCTL   8'h7F
`define RPMC_MASK_ATTEN    8'hFF
`define RPMC_MASK_MIX_L    8'h3E
`define RPMC_MASK_MIX_R    8'h5E

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPMC_BIT_INVERT    6
`define RPMC_BIT_HPF       5
`define RPMC_BIT_PDM_POL   4
`define RPMC_BIT_PDM_SWAP  3
`define RPMC_BIT_PDM_SEL   2
`define RPMC_BIT_MUTE_L    5
`define RPMC_BIT_MUTE_R    6
`define RPMC_BEEP_LSB      1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPMC_RST_REG       8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPMC_CLK_HZ        125000000
`define RPMC_FS_HZ         48000
`define RPMC_BCLK_RATIO    128
`define RPMC_BCLK_HALF     (`RPMC_CLK_HZ / (2 * `RPMC_BCLK_RATIO * `RPMC_FS_HZ))
`define RPMC_HPF_SHIFT     12
`define RPMC_ZC_TO_0       256
`define RPMC_ZC_TO_1       512
`define RPMC_ZC_TO_2       1024
`define RPMC_ZC_TO_3       2048

`endif

//--- src/rpmc_pkg.sv
package rpmc_pkg;

  // Beep gain zero-crossing wait state
  typedef enum logic [0:0] {
    ZC_IDLE = 1'b0,
    ZC_WAIT = 1'b1
  } rpmc_zc_state_t;

  // One stereo record word
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } rpmc_pair_t;

endpackage

//--- src/rpmc_atten_slew.sv
`timescale 1ns/1ps

module rpmc_atten_slew
  import rpmc_pkg::*;
#(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,
  // Target code from register
  input  wire logic [7:0]          i_target,
  // Sample in, one per audio frame
  input  wire logic                i_valid,
  input  wire logic signed [W-1:0] i_sample,
  // Sample out
  output logic                     o_valid,
  output logic signed [W-1:0]      o_sample,
  output logic [7:0]               o_level
);

  initial begin
    if (W < 8 || W > 32) $error("rpmc_atten_slew: W out of range");
  end

  // ----------------------------------------------------------------
  // Gain lookup: 16 steps of 0.375 dB per 6 dB octave
  // ----------------------------------------------------------------
  function automatic logic [15:0] mant(input logic [3:0] k);
    logic [15:0] m;
    m = 16'h8000;
    unique case (k)
      4'h0: m = 16'h8000;
      4'h1: m = 16'h7A93;
      4'h2: m = 16'h7561;
      4'h3: m = 16'h7067;
      4'h4: m = 16'h6BA3;
      4'h5: m = 16'h6712;
      4'h6: m = 16'h62B4;
      4'h7: m = 16'h5E84;
      4'h8: m = 16'h5A82;
      4'h9: m = 16'h56AC;
      4'hA: m = 16'h5300;
      4'hB: m = 16'h4F7B;
      4'hC: m = 16'h4C1C;
      4'hD: m = 16'h48E2;
      4'hE: m = 16'h45CB;
      4'hF: m = 16'h42D6;
    endcase
    return m;
  endfunction

  typedef struct packed {
    logic                valid;
    logic signed [W-1:0] sample;
    logic [7:0]          level;
  } st_t;

  st_t                     s_q;      // Registered state
  st_t                     s_d;      // Next state
  logic [7:0]              lvl;      // Level after this frame's step
  logic signed [W+16:0]    prod;     // Sample times mantissa

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.valid = i_valid;
    lvl       = s_q.level;
    // One step toward target per frame
    if (i_valid && s_q.level < i_target) begin
      lvl = s_q.level + 8'h01;
    end else if (i_valid && s_q.level > i_target) begin
      lvl = s_q.level - 8'h01;
    end
    prod = i_sample * $signed({1'b0, mant(lvl[3:0])});
    if (i_valid) begin
      s_d.level  = lvl;
      s_d.sample = W'(prod >>> (15 + int'(lvl[7:4])));
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_valid  = s_q.valid;
  assign o_sample = s_q.sample;
  assign o_level  = s_q.level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_slew_one_step: assert property (o_valid |-> (o_level == $past(o_level) + 8'h01 ||
    o_level == $past(o_level) - 8'h01 || o_level == $past(o_level)))
    else $error("level moved more than one step");
  a_unity_gain: assert property ((i_valid && i_target == 8'h00 && o_level == 8'h00) |=>
    (o_sample == $past(i_sample))) else $error("code zero not unity");
  a_slew_hold: assert property ((!i_valid) |=> (o_level == $past(o_level)))
    else $error("level moved without frame");

endmodule

//--- src/rpmc_top.sv
`timescale 1ns/1ps
`include "rpmc_map.svh"


module rpmc_top
  import rpmc_pkg::*;
#(
  parameter int BCLK_HALF = `RPMC_BCLK_HALF,
  parameter int HPF_SHIFT = `RPMC_HPF_SHIFT,
  parameter int ZC_TO_0   = `RPMC_ZC_TO_0,
  parameter int ZC_TO_1   = `RPMC_ZC_TO_1,
  parameter int ZC_TO_2   = `RPMC_ZC_TO_2,
  parameter int ZC_TO_3   = `RPMC_ZC_TO_3
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  output logic             o_reg_rvalid,
  // ADC samples in
  input  wire logic        i_adc_valid,
  output logic             o_adc_ready,
  input  wire logic [23:0] i_adc_left,
  input  wire logic [23:0] i_adc_right,
  // Record stream out
  output logic             o_rec_valid,
  input  wire logic        i_rec_ready,
  output logic [23:0]      o_rec_left,
  output logic [23:0]      o_rec_right,
  output logic [1:0]       o_rec_tdm_pair,
  // Converter control
  output logic [1:0]       o_adc_power,
  output logic             o_dac_unmute_left,
  output logic             o_dac_unmute_right,
  // Digital microphone pins
  input  wire logic        i_record_serial_data_pin,
  output logic             o_bclk,
  output logic             o_bclk_oe_n,
  output logic             o_pdm_valid,
  output logic             o_pdm_left,
  output logic             o_pdm_right,
  // Beep
  input  wire logic        i_frame_tick,
  input  wire logic        i_beep_zero_cross,
  input  wire logic        i_zc_enable,
  input  wire logic [1:0]  i_zc_timeout_sel,
  output logic [3:0]       o_beep_gain_left
);

  initial begin
    if (BCLK_HALF < 1 || HPF_SHIFT < 1 || HPF_SHIFT > 20) $error("rpmc_top: bad parameter");
    if (ZC_TO_0 < 1 || ZC_TO_1 < 1 || ZC_TO_2 < 1 || ZC_TO_3 < 1) $error("rpmc_top: bad timeout");
  end

  localparam int AW = 24 + HPF_SHIFT + 2;   // High-pass accumulator width

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  function automatic logic [23:0] neg_sat(input logic [23:0] x);
    return (x == 24'h80_0000) ? 24'h7F_FFFF : 24'(-x);
  endfunction

  function automatic logic [11:0] zc_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: return 12'(ZC_TO_0 - 1);
      2'b01: return 12'(ZC_TO_1 - 1);
      2'b10: return 12'(ZC_TO_2 - 1);
      2'b11: return 12'(ZC_TO_3 - 1);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            slot;      // Record TDM pair
    logic [7:0]            recctl;    // Record path control
    logic [7:0]            att_l;     // Left attenuator target
    logic [7:0]            att_r;     // Right attenuator target
    logic [7:0]            mix_l;     // Left mixer
    logic [7:0]            mix_r;     // Right mixer
    logic [7:0]            rdata;     // Read data
    logic                  rvalid;    // Read answer strobe
    logic                  ready;     // Input acceptance
    logic                  stg_v;     // Processed sample valid
    rpmc_pair_t            stg;       // Processed sample
    rpmc_pair_t            x1;        // Previous input per channel
    logic signed [AW-1:0]  acc_l;     // Left high-pass state
    logic signed [AW-1:0]  acc_r;     // Right high-pass state
    rpmc_pair_t [1:0]      mem;       // Two-entry buffer
    logic                  wp;        // Write pointer
    logic                  rp;        // Read pointer
    logic [1:0]            cnt;       // Buffer fill
    logic                  out_v;     // Stream valid
    rpmc_pair_t            out;       // Stream word
    logic [1:0]            adc_pwr;   // ADC power
    logic [15:0]           div;       // Bit clock divider
    logic                  bclk;      // Bit clock level
    logic                  bclk_oe_n; // Bit clock drive enable
    logic                  pdm_v;     // Mic pair strobe
    logic                  pdm_l;     // Left mic bit
    logic                  pdm_r;     // Right mic bit
    rpmc_zc_state_t        zc;        // Beep wait state
    logic [3:0]            beep_pend; // Pending beep gain
    logic [3:0]            beep;      // Applied beep gain
    logic [11:0]           zc_cnt;    // Timeout frame count
  } st_t;

  st_t                   s_q;        // Registered state
  st_t                   s_d;        // Next state
  logic                  rst_meta;   // Reset synchroniser stage 1
  logic                  rst_n;      // Synchronised reset
  logic                  sl_v_l;     // Left attenuator out valid
  logic                  sl_v_r;     // Right attenuator out valid
  logic signed [23:0]    sl_l;       // Left attenuated sample
  logic signed [23:0]    sl_r;       // Right attenuated sample
  logic                  acc_in;     // Sample accepted this cycle
  logic                  wr_in;      // Buffer write this cycle
  logic                  rd_out;     // Buffer read this cycle
  logic [23:0]           xl;         // Gated left input
  logic [23:0]           xr;         // Gated right input
  logic signed [AW-1:0]  al;         // Left accumulator next
  logic signed [AW-1:0]  ar;         // Right accumulator next
  logic                  edge_ev;    // Bit clock edge event
  logic                  pulse;      // Mic pulse bit

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Attenuators
  // ----------------------------------------------------------------
  rpmc_atten_slew #(.W(24)) u_slew_l (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_target  (s_q.att_l),
    .i_valid   (s_q.stg_v),
    .i_sample  (s_q.stg.left),
    .o_valid   (sl_v_l),
    .o_sample  (sl_l),
    .o_level   ()
  );

  rpmc_atten_slew #(.W(24)) u_slew_r (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_target  (s_q.att_r),
    .i_valid   (s_q.stg_v),
    .i_sample  (s_q.stg.right),
    .o_valid   (sl_v_r),
    .o_sample  (sl_r),
    .o_level   ()
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.rvalid = 1'b0;
    s_d.pdm_v  = 1'b0;
    // Register writes, reserved bits dropped
    if (i_reg_wr) begin
      if (hit(i_reg_addr, `RPMC_OFF_SLOT))    s_d.slot   = i_reg_wdata & `RPMC_MASK_SLOT;
      if (hit(i_reg_addr, `RPMC_OFF_RECCTL))  s_d.recctl = i_reg_wdata & `RPMC_MASK_RECCTL;
      if (hit(i_reg_addr, `RPMC_OFF_ATTEN_L)) s_d.att_l  = i_reg_wdata;
      if (hit(i_reg_addr, `RPMC_OFF_ATTEN_R)) s_d.att_r  = i_reg_wdata;
      if (hit(i_reg_addr, `RPMC_OFF_MIX_L))   s_d.mix_l  = i_reg_wdata & `RPMC_MASK_MIX_L;
      if (hit(i_reg_addr, `RPMC_OFF_MIX_R))   s_d.mix_r  = i_reg_wdata & `RPMC_MASK_MIX_R;
    end
    // Register reads, unmapped reads zero
    if (i_reg_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 8'h00;
      if (hit(i_reg_addr, `RPMC_OFF_SLOT))    s_d.rdata = s_q.slot;
      if (hit(i_reg_addr, `RPMC_OFF_RECCTL))  s_d.rdata = s_q.recctl;
      if (hit(i_reg_addr, `RPMC_OFF_ATTEN_L)) s_d.rdata = s_q.att_l;
      if (hit(i_reg_addr, `RPMC_OFF_ATTEN_R)) s_d.rdata = s_q.att_r;
      if (hit(i_reg_addr, `RPMC_OFF_MIX_L))   s_d.rdata = s_q.mix_l;
      if (hit(i_reg_addr, `RPMC_OFF_MIX_R))   s_d.rdata = s_q.mix_r;
    end
    // ADC power follows enable unless mics selected
    s_d.adc_pwr = s_q.recctl[`RPMC_BIT_PDM_SEL] ? 2'b00 : s_q.recctl[1:0];
    // Input stage: gate, invert, high-pass
    acc_in = i_adc_valid && s_q.ready;
    xl = s_q.adc_pwr[0] ? i_adc_left : 24'h00_0000;
    xr = s_q.adc_pwr[1] ? i_adc_right : 24'h00_0000;
    if (s_q.recctl[`RPMC_BIT_INVERT]) begin
      xl = neg_sat(xl);
      xr = neg_sat(xr);
    end
    al = (AW'($signed(xl)) - AW'($signed(s_q.x1.left)) <<< HPF_SHIFT) + s_q.acc_l - (s_q.acc_l >>> HPF_SHIFT);
    ar = (AW'($signed(xr)) - AW'($signed(s_q.x1.right)) <<< HPF_SHIFT) + s_q.acc_r - (s_q.acc_r >>> HPF_SHIFT);
    s_d.stg_v = acc_in;
    if (acc_in) begin
      s_d.x1.left  = xl;
      s_d.x1.right = xr;
      s_d.acc_l    = al;
      s_d.acc_r    = ar;
      if (s_q.recctl[`RPMC_BIT_HPF]) begin
        s_d.stg.left  = 24'(al >>> HPF_SHIFT);
        s_d.stg.right = 24'(ar >>> HPF_SHIFT);
      end else begin
        s_d.stg.left  = xl;
        s_d.stg.right = xr;
      end
    end
    // Two-entry buffer
    wr_in  = sl_v_l && sl_v_r;
    rd_out = s_q.out_v && i_rec_ready;
    if (wr_in) begin
      s_d.mem[s_q.wp] = '{left: sl_l, right: sl_r};
      s_d.wp          = !s_q.wp;
    end
    if (rd_out) begin
      s_d.rp = !s_q.rp;
    end
    s_d.cnt   = s_q.cnt + 2'(wr_in) - 2'(rd_out);
    s_d.out_v = s_d.cnt != 2'b00;
    s_d.out   = s_d.mem[s_d.rp];
    // Stall input so in-flight words always fit
    s_d.ready = (3'(s_d.cnt) + 3'(s_d.stg_v) + 3'(s_q.stg_v)) < 3'd2;
    // Bit clock master for microphones
    edge_ev = 1'b0;
    if (s_q.recctl[`RPMC_BIT_PDM_SEL]) begin
      s_d.bclk_oe_n = 1'b0;
      if (s_q.div == 16'(BCLK_HALF - 1)) begin
        s_d.div  = 16'h0000;
        s_d.bclk = !s_q.bclk;
        edge_ev  = 1'b1;
      end else begin
        s_d.div = s_q.div + 16'h0001;
      end
    end else begin
      s_d.bclk_oe_n = 1'b1;
      s_d.bclk      = 1'b0;
      s_d.div       = 16'h0000;
    end
    // Mic capture: edge picks channel, polarity picks pulse level
    pulse = i_record_serial_data_pin ^ !s_q.recctl[`RPMC_BIT_PDM_POL];
    if (edge_ev) begin
      if (s_d.bclk ^ s_q.recctl[`RPMC_BIT_PDM_SWAP]) begin
        s_d.pdm_l = pulse;
      end else begin
        s_d.pdm_r = pulse;
      end
      s_d.pdm_v = !s_d.bclk;
    end
    // Beep gain, held until zero crossing or timeout
    if (i_reg_wr && hit(i_reg_addr, `RPMC_OFF_MIX_L)) begin
      s_d.beep_pend = i_reg_wdata[`RPMC_BEEP_LSB +: 4];
      s_d.zc_cnt    = 12'h000;
      if (i_zc_enable) begin
        s_d.zc = ZC_WAIT;
      end else begin
        s_d.zc   = ZC_IDLE;
        s_d.beep = i_reg_wdata[`RPMC_BEEP_LSB +: 4];
      end
    end else begin
      unique case (s_q.zc)
        ZC_IDLE: begin
          s_d.zc_cnt = 12'h000;
        end
        ZC_WAIT: begin
          if (i_beep_zero_cross) begin
            s_d.beep = s_q.beep_pend;
            s_d.zc   = ZC_IDLE;
          end else if (i_frame_tick && s_q.zc_cnt >= zc_limit(i_zc_timeout_sel)) begin
            s_d.beep = s_q.beep_pend;
            s_d.zc   = ZC_IDLE;
          end else if (i_frame_tick) begin
            s_d.zc_cnt = s_q.zc_cnt + 12'h001;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.ready     <= 1'b1;
      s_q.bclk_oe_n <= 1'b1;
      s_q.zc        <= ZC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata        = s_q.rdata;
  assign o_reg_rvalid       = s_q.rvalid;
  assign o_adc_ready        = s_q.ready;
  assign o_rec_valid        = s_q.out_v;
  assign o_rec_left         = s_q.out.left;
  assign o_rec_right        = s_q.out.right;
  assign o_rec_tdm_pair     = s_q.slot[1:0];
  assign o_adc_power        = s_q.adc_pwr;
  assign o_dac_unmute_left  = s_q.mix_l[`RPMC_BIT_MUTE_L];
  assign o_dac_unmute_right = s_q.mix_r[`RPMC_BIT_MUTE_R];
  assign o_bclk             = s_q.bclk;
  assign o_bclk_oe_n        = s_q.bclk_oe_n;
  assign o_pdm_valid        = s_q.pdm_v;
  assign o_pdm_left         = s_q.pdm_l;
  assign o_pdm_right        = s_q.pdm_r;
  assign o_beep_gain_left   = s_q.beep;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_mix_l_write;
    i_reg_wr && i_reg_addr == `RPMC_OFF_MIX_L;
  endsequence

  a_slot_pair: assert property ((i_reg_wr && i_reg_addr == `RPMC_OFF_SLOT) |=>
    o_rec_tdm_pair == $past(i_reg_wdata[1:0])) else $error("slot pair not applied");
  a_invert_path: assert property ((o_adc_ready && i_adc_valid && o_adc_power == 2'b11 &&
    s_q.recctl[6:5] == 2'b10 && i_adc_left != 24'h80_0000) |=> s_q.stg.left == 24'(-$past(i_adc_left)))
    else $error("invert not applied");
  a_plain_path: assert property ((o_adc_ready && i_adc_valid && o_adc_power[0] &&
    s_q.recctl[6:5] == 2'b00) |=> s_q.stg.left == $past(i_adc_left)) else $error("path altered");
  a_pdm_capture: assert property ((edge_ev && !s_d.bclk && !s_q.recctl[3] && !s_q.recctl[4]) |=>
    o_pdm_right == !$past(i_record_serial_data_pin) && o_pdm_valid) else $error("mic capture wrong");
  a_bclk_master: assert property ($rose(s_q.recctl[2]) |=> !o_bclk_oe_n && o_adc_power == 2'b00)
    else $error("mic mode not entered");
  a_adc_enable: assert property ((!s_q.recctl[2]) |=> o_adc_power == $past(s_q.recctl[1:0]))
    else $error("adc power mismatch");
  a_dac_mute: assert property ((i_reg_wr && i_reg_addr == `RPMC_OFF_MIX_R) |=>
    o_dac_unmute_right == $past(i_reg_wdata[6])) else $error("right mute late");
  a_beep_wait: assert property ((s_mix_l_write ##0 i_zc_enable) |=> s_q.zc == ZC_WAIT)
    else $error("beep gain not held");
  a_beep_zc: assert property ((s_q.zc == ZC_WAIT && i_beep_zero_cross && !i_reg_wr) |=>
    o_beep_gain_left == $past(s_q.beep_pend)) else $error("beep not applied at crossing");
  a_reserved_zero: assert property ((i_reg_rd && i_reg_addr == `RPMC_OFF_MIX_L) |=>
    o_reg_rvalid && o_reg_rdata[7:6] == 2'b00 && !o_reg_rdata[0]) else $error("reserved bits set");

endmodule

//--- verification/rpmc_mic_model.sv
`timescale 1ns/1ps

// Stereo digital microphone on the record data pin
module rpmc_mic_model (
  // Clock and link
  input  wire logic i_clk,
  input  wire logic i_bclk_oe_n,
  input  wire logic i_level,
  // Data pin
  output logic      o_data
);
  // Drives its level while clocked, a toggling pattern once released
  initial o_data = 1'b0;
  always @(posedge i_clk) o_data <= i_bclk_oe_n ? ~o_data : i_level;
endmodule

//--- verification/record_path_and_mixer_control_tb.sv
`timescale 1ns/1ps

module record_path_and_mixer_control_tb;
  import rpmc_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} rpmc_row_t;
  // Stimulus and observed signals
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, av = 0, rdy = 1, ft = 0, zc = 0, lvl = 0;
  logic [15:0] ad = 0;
  logic [7:0]  wd = 0, q, rdat;
  logic [23:0] ain = 24'h40_0000, rl, rr;
  logic [1:0]  tdm, pwr;
  logic [3:0]  gain;
  logic        pin, rv, arw, vld, bclk, oe_n, pv, pl, pr, unl, unr;
  int          n_mismatch = 0, check_count = 0, n_in = 0, n_out = 0;
  // Register rows: address, write value, read-back value
  rpmc_row_t   rows [7] = '{'{16'h4018, 8'hFF, 8'h03}, '{16'h4019, 8'h80, 8'h00}, '{16'h401A, 8'hA5, 8'hA5},
    '{16'h401B, 8'h5A, 8'h5A}, '{16'h401C, 8'hC1, 8'h00}, '{16'h401D, 8'h77, 8'h00}, '{16'h401E, 8'hA1, 8'h00}};
  logic [7:0]  pc [4] = '{8'h03, 8'h01, 8'h02, 8'h07};

  rpmc_top #(.BCLK_HALF(2), .ZC_TO_0(2)) rpmc_top_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_adc_valid(av), .o_adc_ready(arw), .i_adc_left(ain),
    .i_adc_right(ain), .o_rec_valid(vld), .i_rec_ready(rdy), .o_rec_left(rl), .o_rec_right(rr),
    .o_rec_tdm_pair(tdm), .o_adc_power(pwr), .o_dac_unmute_left(unl), .o_dac_unmute_right(unr),
    .i_record_serial_data_pin(pin), .o_bclk(bclk), .o_bclk_oe_n(oe_n), .o_pdm_valid(pv), .o_pdm_left(pl),
    .o_pdm_right(pr), .i_frame_tick(ft), .i_beep_zero_cross(zc), .i_zc_enable(1'b1),
    .i_zc_timeout_sel(2'b00), .o_beep_gain_left(gain));
  rpmc_mic_model rpmc_mic_model_inst (.i_clk(clk), .i_bclk_oe_n(oe_n), .i_level(lvl), .o_data(pin));

  initial forever #4 clk = ~clk;
  // Count words entering and leaving the record buffer
  always @(posedge clk) begin
    n_in  <= n_in + int'(av && arw);
    n_out <= n_out + int'(vld && rdy);
  end

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk) {wr, ad, wd} = {1'b1, a, d};
    @(negedge clk) wr = 0;
  endtask
  task automatic rreg(input logic [15:0] a);
    @(negedge clk) {rd, ad} = {1'b1, a};
    @(negedge clk) rd = 0;
    q = rdat;
    check("rvalid", rv, 1);
  endtask
  // Waits for three microphone pairs, then checks both pulse bits
  task automatic mic(input logic [7:0] c, input logic lv, input logic exp);
    int n;
    n = 0;
    lvl = lv;
    wreg(16'h4019, c);
    repeat (60) begin
      @(negedge clk);
      if (pv === 1'b1) n++;
      if (n == 3) break;
    end
    check("pdm", {pl, pr}, {exp, exp});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #50us;
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      rreg(rows[i].a);
      check("reset", q, 0);
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a);
      check("reg", q, rows[i].e);
    end
    // Eight-slot operation assumed, so all four pair codes are legal
    for (int c = 0; c < 4; c++) begin
      wreg(16'h4018, 8'(c));
      check("pair", tdm, 24'(c));
    end
    foreach (pc[i]) begin
      wreg(16'h4019, pc[i]);
      @(negedge clk);
      check("power", pwr, pc[i][2] ? 0 : pc[i][1:0]);
      check("bclk_oe", oe_n, !pc[i][2]);
    end
    mic(8'h04, 0, 1);
    mic(8'h14, 1, 1);
    mic(8'h14, 0, 0);
    wreg(16'h401C, 8'h20);
    check("mute_l", unl, 1);
    wreg(16'h401E, 8'h40);
    check("mute_r", unr, 1);
    wreg(16'h401C, 8'h22);
    check("beep_hold", gain, 0);
    @(negedge clk) zc = 1;
    @(negedge clk) zc = 0;
    @(negedge clk);
    check("beep_zc", gain, 1);
    wreg(16'h401C, 8'h24);
    repeat (2) begin
      @(negedge clk) ft = 1;
      @(negedge clk) ft = 0;
    end
    @(negedge clk);
    check("beep_timeout", gain, 2);
    wreg(16'h4019, 8'h43);
    @(negedge clk) {rdy, av} = 2'b01;
    repeat (8) @(negedge clk);
    check("full", arw, 0);
    check("invert", {rl[23], rr[23]}, 2'b11);
    av = 0;
    rdy = 1;
    repeat (10) @(negedge clk);
    check("drain", n_out, n_in);
    check("empty", vld, 0);
    final_report();
  end
endmodule
